// >>> src/dnp_gen.sv
`timescale 1ns/1ns
// Operation
// - pulse stays asserted at least thirty milliseconds unless reset or power-down ends it
// - one pulse, then locked until reset/rearm
// - causes latched; cause read returns and clears
// - agent cause registration recorded and triggers
// - enable flag gates, resets enabled on mains
// - five trigger sources each start a pulse, pre-timeout only with its action set
// - only button press requests a log event
// - pre-timeout maps to pulse, no other signal
// - button low fifty milliseconds before asserted
module dnp_gen #(
   parameter int unsigned PULSE_CYC = dnp_pkg::PULSE_CYC,
   parameter int unsigned HOLD_CYC = dnp_pkg::DEBOUNCE_CYC
) (
   // clock, reset, enable
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // power events: mains cycle resets the enable flag, power-down rearms
   input wire logic ac_cycle_i,
   input wire logic pwr_down_i,
   // trigger requests, one-cycle pulses from on-clock logic
   input wire logic chassis_req_i,
   input wire logic filter_req_i,
   input wire logic wdog_pretmo_i,
   input wire logic wdog_nmi_act_i,
   input wire logic agent_set_i,
   input wire logic [dnp_pkg::SRC_W-1:0] agent_cause_i,
   // raw front button pin, active low
   input wire logic btn_n_i,
   // enable/disable command; enable also rearms
   input wire logic en_wr_i,
   input wire logic en_val_i,
   // cause query
   input wire logic cause_rd_i,
   output logic [dnp_pkg::SRC_W-1:0] cause_o,
   output logic cause_vld_o,
   // status
   output logic en_o,
   output logic locked_o,
   output logic btn_held_o,
   // pulse toward host and log request
   output logic nmi_o,
   output logic log_evt_o
);
   localparam int unsigned PW = $clog2(PULSE_CYC + 1);

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_PULSE = 3'b010,
      ST_LOCK = 3'b100
   } dnp_state_e;

   dnp_trig_if trig ();
   dnp_state_e state_q;
   logic [PW-1:0] pcnt_q;
   logic en_q;
   logic [dnp_pkg::SRC_W-1:0] cause_q;
   logic [dnp_pkg::SRC_W-1:0] hit;
   logic fire;
   logic log_q;
   logic [dnp_pkg::SRC_W-1:0] rd_q;
   logic rd_vld_q;
   logic rearm;

   dnp_debounce #(.HOLD_CYC(HOLD_CYC)) u_deb (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .btn_n_i(btn_n_i),
      .trig(trig)
   );

   // per-source request vector; pre-timeout counts only with its action set
   always_comb begin
      hit = '0;
      hit[dnp_pkg::SRC_CHASSIS] = chassis_req_i;
      hit[dnp_pkg::SRC_BUTTON] = trig.press;
      hit[dnp_pkg::SRC_FILTER] = filter_req_i;
      hit[dnp_pkg::SRC_WDOG] = wdog_pretmo_i & wdog_nmi_act_i;
      if (agent_set_i) begin
         hit = hit | agent_cause_i;
      end
   end
   // an agent command triggers even with an empty cause field
   assign fire = ((|hit) | agent_set_i) & en_q;
   assign rearm = en_wr_i & en_val_i;

   // enable flag: volatile, back to enabled on reset or mains cycle only
   always_ff @(posedge mclk_i) begin
      if (rst_i || ac_cycle_i) begin
         en_q <= dnp_pkg::EN_RST;
      end else if (ce_i && en_wr_i) begin
         en_q <= en_val_i;
      end
   end

   // idle -> pulse -> locked; system reset, power-down or enable rearms
   always_ff @(posedge mclk_i) begin
      if (rst_i || pwr_down_i) begin
         state_q <= ST_IDLE;
         pcnt_q <= '0;
      end else if (ce_i) begin
         unique case (state_q)
            ST_IDLE: begin
               if (fire) begin
                  state_q <= ST_PULSE;
                  pcnt_q <= '0;
               end
            end
            ST_PULSE: begin
               if (pcnt_q == PW'(PULSE_CYC - 1)) begin
                  state_q <= ST_LOCK;
               end else begin
                  pcnt_q <= pcnt_q + PW'(1);
               end
            end
            ST_LOCK: begin
               // rearm never cuts a pulse short, it only frees the lock
               if (rearm) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // causes gather from every source at all times; set wins over the read clear
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cause_q <= dnp_pkg::CAUSE_RST;
         rd_q <= '0;
         rd_vld_q <= 1'b0;
      end else if (ce_i) begin
         rd_vld_q <= cause_rd_i;
         if (cause_rd_i) begin
            rd_q <= cause_q;
            cause_q <= hit;
         end else begin
            cause_q <= cause_q | hit;
         end
      end
   end

   // log request only for a button press that really fires a pulse
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         log_q <= 1'b0;
      end else if (ce_i) begin
         log_q <= trig.press & fire & (state_q == ST_IDLE) & ~pwr_down_i;
      end
   end

   assign nmi_o = (state_q == ST_PULSE);
   assign log_evt_o = log_q;
   assign cause_o = rd_q;
   assign cause_vld_o = rd_vld_q;
   assign en_o = en_q;
   assign locked_o = (state_q == ST_LOCK);
   assign btn_held_o = trig.held;
endmodule

// >>> src/dnp_pkg.sv
package dnp_pkg;
   // controller clock rate
   localparam int unsigned CLK_HZ = 20000000;
   // least pulse width and button hold time, in microseconds
   localparam int unsigned PULSE_MIN_US = 30000;
   localparam int unsigned DEBOUNCE_US = 50000;
   // least times scale to cycles by the clock rate in whole MHz, rounded down
   localparam int unsigned PULSE_CYC = (PULSE_MIN_US * (CLK_HZ / 1000000) + 0) ;
   localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_US * (CLK_HZ / 1000000));
   // cause bit positions
   localparam int unsigned SRC_CHASSIS = 0;
   localparam int unsigned SRC_BUTTON = 1;
   localparam int unsigned SRC_FILTER = 2;
   localparam int unsigned SRC_WDOG = 3;
   localparam int unsigned SRC_AGENT = 4;
   localparam int unsigned SRC_W = 5;
   // reset values
   localparam logic EN_RST = 1'b1;
   localparam logic [SRC_W-1:0] CAUSE_RST = 5'h00;
endpackage

// >>> src/dnp_trig_if.sv
`timescale 1ns/1ns
// debounced button handed from the filter to the generator
interface dnp_trig_if;
   logic press;
   logic held;
   modport filt (output press, output held);
   modport gen (input press, input held);
endinterface

// >>> src/dnp_debounce.sv
`timescale 1ns/1ns
module dnp_debounce #(
   parameter int unsigned HOLD_CYC = dnp_pkg::DEBOUNCE_CYC
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // raw active-low button pin
   input wire logic btn_n_i,
   // debounced result
   dnp_trig_if.filt trig
);
   localparam int unsigned CW = $clog2(HOLD_CYC + 1);
   logic sync1_q;
   logic sync2_q;
   logic [CW-1:0] cnt_q;
   logic held_q;
   logic press_q;

   // two-stage synchroniser, idle high so reset reads as released
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
      end else if (ce_i) begin
         sync1_q <= btn_n_i;
         sync2_q <= sync1_q;
      end
   end

   // any high sample restarts the count, so bounce never accumulates
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
         held_q <= 1'b0;
         press_q <= 1'b0;
      end else if (ce_i) begin
         press_q <= 1'b0;
         if (sync2_q) begin
            cnt_q <= '0;
            held_q <= 1'b0;
         end else if (cnt_q == CW'(HOLD_CYC - 1)) begin
            press_q <= ~held_q;
            held_q <= 1'b1;
         end else begin
            cnt_q <= cnt_q + CW'(1);
         end
      end
   end

   assign trig.press = press_q;
   assign trig.held = held_q;
endmodule

// >>> dv/dnp_gen_props.sv
`timescale 1ns/1ns
// pin checks; ce_i is assumed high, as the bench keeps it
module dnp_gen_props #(parameter int unsigned PULSE_CYC = 20) (
   // watched pins
   input wire logic mclk_i, rst_i, en_wr_i, en_val_i, ac_cycle_i, pwr_down_i, cause_rd_i, chassis_req_i,
   input wire logic filter_req_i, wdog_pretmo_i, wdog_nmi_act_i, agent_set_i, cause_vld_o, en_o, locked_o,
   input wire logic btn_held_o, nmi_o, log_evt_o,
   input wire logic [4:0] cause_o
);
   logic [31:0] cnt_q;
   wire trg = chassis_req_i | filter_req_i | agent_set_i | wdog_pretmo_i & wdog_nmi_act_i;
   wire calm = !(en_wr_i | pwr_down_i | ac_cycle_i);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // pulse high time, zeroed while low
   always_ff @(posedge mclk_i) cnt_q <= (nmi_o && !rst_i) ? cnt_q + 32'h1 : 32'h0;
   // a read while no cause can arrive
   sequence s_rd;
      cause_rd_i && !trg && !btn_held_o;
   endsequence
   a_nmi_start: assert property (trg && en_o && !nmi_o && !locked_o && calm |=> nmi_o) else $error("no pulse");
   a_pulse_width: assert property ($fell(nmi_o) && $past(calm) |-> cnt_q == PULSE_CYC && locked_o) else $error("width");
   a_locked_quiet: assert property (locked_o && calm |=> !nmi_o) else $error("second pulse");
   a_disabled_quiet: assert property (!en_o && !nmi_o && calm |=> !nmi_o) else $error("pulse while off");
   a_en_write: assert property (en_wr_i && !ac_cycle_i |=> en_o == $past(en_val_i)) else $error("enable");
   a_vld_read: assert property (cause_vld_o |-> $past(cause_rd_i)) else $error("stray valid");
   a_read_clears: assert property (s_rd ##1 s_rd |=> cause_o == 5'h00) else $error("cause kept");
   a_log_button: assert property (log_evt_o |-> $rose(nmi_o) && $past(btn_held_o)) else $error("log");
endmodule
bind dnp_gen dnp_gen_props #(.PULSE_CYC(PULSE_CYC)) dnp_gen_props_inst (.*);

// >>> dv/dnp_host_model.sv
`timescale 1ns/1ns
// host interrupt pin: pulse count and width of the last one
module dnp_host_model (
   input wire logic mclk_i,
   input wire logic nmi_i,
   output int n_pulse_o,
   output int width_o
);
   int run;
   // width is taken on the fall
   always @(posedge mclk_i) begin
      run <= nmi_i ? run + 1 : 0;
      if (!nmi_i && run != 0) begin
         n_pulse_o <= n_pulse_o + 1;
         width_o <= run;
      end
   end
endmodule

// >>> dv/dnp_gen_tb.sv
`timescale 1ns/1ns
module dnp_gen_tb;
   logic mclk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, ac_cycle_i = 1'b0, pwr_down_i = 1'b0, btn_n_i = 1'b1;
   logic chassis_req_i = 1'b0, filter_req_i = 1'b0, wdog_pretmo_i = 1'b0, wdog_nmi_act_i = 1'b1;
   logic agent_set_i = 1'b0, en_wr_i = 1'b0, en_val_i = 1'b0, cause_rd_i = 1'b0;
   logic cause_vld_o, en_o, locked_o, btn_held_o, nmi_o, log_evt_o;
   logic [4:0] agent_cause_i = 5'h00, cause_o;
   int n_mismatch, checked, n_pulse, width, n_log, n_exp, cm, lk, en = 1;
   integer seed = 32'had38158b;
   dnp_gen #(.PULSE_CYC(20), .HOLD_CYC(10)) dnp_gen_inst (.*);
   dnp_host_model dnp_host_model_inst (.mclk_i, .nmi_i(nmi_o), .n_pulse_o(n_pulse), .width_o(width));
   initial forever #25 mclk_i = ~mclk_i;
   always @(posedge mclk_i) if (log_evt_o === 1'b1) n_log <= n_log + 1;
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("Error %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   task final_report;
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   // one trigger; the model keeps the cause and pulses only when idle and enabled
   task go(input int s);
      cyc(1);
      {agent_set_i, wdog_pretmo_i, filter_req_i, chassis_req_i} <= 4'h1 << s;
      agent_cause_i <= 5'($random(seed));
      cyc(1);
      {agent_set_i, wdog_pretmo_i, filter_req_i, chassis_req_i} <= 4'h0;
      if (s == 2 && !wdog_nmi_act_i) return;
      cm |= s == 3 ? agent_cause_i : 5'h01 << s + (s > 0);
      if (en && !lk) begin
         n_exp++;
         lk = 1;
      end
   endtask
   // long enough for a whole pulse at the shortened width
   task settle;
      cyc(25);
      #1;
      chk("pulses", n_pulse, n_exp);
      chk("width", width, 20);
      chk("locked", locked_o, lk);
   endtask
   task rd(input int n);
      cyc(1);
      cause_rd_i <= 1'b1;
      cyc(n);
      cause_rd_i <= 1'b0;
      #1;
      chk("cause", cause_o, cm);
      chk("valid", cause_vld_o, 1'b1);
      cm = 0;
   endtask
   // writing one also rearms
   task wr(input logic v);
      cyc(1);
      {en_wr_i, en_val_i} <= {1'b1, v};
      cyc(1);
      en_wr_i <= 1'b0;
      #1;
      en = v;
      if (v) lk = 0;
      chk("enable", en_o, v);
   endtask
   initial begin
      cyc(3);
      rst_i <= 1'b0;
      rd(2);
      for (int s = 0; s < 4; s++) begin
         wr(1'b1);
         go(s);
         go((s + 1) % 4);
         settle;
         rd(1);
      end
      wdog_nmi_act_i <= 1'b0;
      wr(1'b1);
      go(2);
      settle;
      wdog_nmi_act_i <= 1'b1;
      wr(1'b0);
      go(0);
      settle;
      rd(1);
      ac_cycle_i <= 1'b1;
      cyc(1);
      ac_cycle_i <= 1'b0;
      en = 1;
      go(1);
      settle;
      pwr_down_i <= 1'b1;
      cyc(1);
      pwr_down_i <= 1'b0;
      lk = 0;
      chk("log", n_log, 0);
      btn_n_i <= 1'b0;
      cyc(20);
      #1;
      chk("held", btn_held_o, 1'b1);
      btn_n_i <= 1'b1;
      cm |= 2;
      n_exp++;
      lk = 1;
      settle;
      chk("log", n_log, 1);
      rd(1);
      final_report;
   end
   initial begin
      cyc(3000);
      n_mismatch++;
      final_report;
   end
endmodule
